// File: design/clock_select_regs.svh
`ifndef CLOCK_SELECT_REGS_SVH
`define CLOCK_SELECT_REGS_SVH

// Register indices; the byte address is four times the index
`define OSC_CONTROL_IDX 8'hB2
`define OSC_PERIOD_TRIM_IDX 8'hB3

// Control register field positions
`define CTL_READY_BIT 4
`define CTL_CLKSEL_BIT 3
`define CTL_ENABLE_BIT 2
`define CTL_DIV_MSB 1
`define CTL_DIV_LSB 0
`define TRIM_MSB 6

// Reset values
`define OSC_CONTROL_RST 8'h14
`define DIV_RST 2'h0
`define TRIM_RST 7'h00

// Divide select encodings
`define DIV_BY8 2'h0
`define DIV_BY4 2'h1
`define DIV_BY2 2'h2
`define DIV_BY1 2'h3

// Internal oscillator edges to settle after enable or trim change
`define OSC_SETTLE_EDGES 8'h10

`endif

// File: design/clock_select_pkg.sv
package clock_select_pkg;

    // Register selected by an AHB address phase
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_TRIM,
        SEL_CONTROL
    } reg_sel_t;

    // Controls driven to the internal oscillator macro
    typedef struct packed {
        logic enable;
        logic [6:0] trim;
    } osc_ctrl_t;

    // Whole state of the clock select block
    typedef struct packed {
        logic [6:0] trim;
        logic trimLoaded;
        logic clkSel;
        logic oscEn;
        logic [1:0] divSel;
        logic actSel;
        logic [1:0] actDiv;
        logic [7:0] settleCnt;
        logic ready;
        logic sysClk;
        logic intSync1;
        logic intSync2;
        logic intPrev;
        logic extSync1;
        logic extSync2;
        logic [2:0] divCnt;
        logic dpWrite;
        reg_sel_t dpSel;
        logic [31:0] rdata;
    } state_t;

endpackage

// File: design/system_clock_source_select.sv
// Operation
// - Any reset leaves the internal oscillator as the system clock source with no software help.
// - Software can change the internal oscillator period through a writable trim value.
// - On calibrated parts the trim comes out of reset holding the factory value for nominal frequency.
// - The internal oscillator is divided by 1, 2, 4 or 8 as chosen by the two-bit divide select.
// - After reset the divide select holds the divide by eight setting.
// - The sources are the external oscillator, the undivided and the divided internal oscillator.
// - Software can enable and disable the internal oscillator through a control bit.
// - The external oscillator may keep running while unused and can be selected again at any time.
// - A read-only ready flag reads one once the internal oscillator runs at its programmed frequency.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_regs.svh"

module system_clock_source_select #(
    parameter logic CALIBRATED = 1'b1,
    parameter logic [6:0] UNCAL_TRIM = `TRIM_RST,
    parameter logic [7:0] SETTLE_EDGES = `OSC_SETTLE_EDGES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Oscillator inputs
    input wire logic intOscIn,
    input wire logic extOscIn,
    input wire logic [6:0] factoryTrim,
    // Oscillator control and system clock
    output clock_select_pkg::osc_ctrl_t oscCtrl,
    output logic sysClk,
    output logic extSelected
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset images of the control fields

    // Field values unpacked from the control register reset word
    localparam logic RST_READY = 1'(`OSC_CONTROL_RST >> `CTL_READY_BIT);
    localparam logic RST_CLKSEL = 1'(`OSC_CONTROL_RST >> `CTL_CLKSEL_BIT);
    localparam logic RST_OSCEN = 1'(`OSC_CONTROL_RST >> `CTL_ENABLE_BIT);
    localparam logic [1:0] RST_DIV = 2'(`OSC_CONTROL_RST >> `CTL_DIV_LSB);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and register read helpers

    // Maps a byte address onto a register
    function automatic clock_select_pkg::reg_sel_t decodeAddr(input logic [31:0] addr);
        clock_select_pkg::reg_sel_t sel;
        sel = clock_select_pkg::SEL_NONE;
        if (addr == {22'h000000, `OSC_PERIOD_TRIM_IDX, 2'h0}) begin
            sel = clock_select_pkg::SEL_TRIM;
        end else if (addr == {22'h000000, `OSC_CONTROL_IDX, 2'h0}) begin
            sel = clock_select_pkg::SEL_CONTROL;
        end
        return sel;
    endfunction

    // Control register image; bits 7 to 5 read zero
    function automatic logic [7:0] controlImage(input clock_select_pkg::state_t st);
        logic [7:0] img;
        img = 8'h00;
        img[`CTL_READY_BIT] = st.ready;
        img[`CTL_CLKSEL_BIT] = st.clkSel;
        img[`CTL_ENABLE_BIT] = st.oscEn;
        img[`CTL_DIV_MSB:`CTL_DIV_LSB] = st.divSel;
        return img;
    endfunction

    // Read value of a register; unused bits read zero
    function automatic logic [31:0] readReg(input clock_select_pkg::state_t st,
                                            input clock_select_pkg::reg_sel_t sel);
        logic [31:0] val;
        val = 32'h00000000;
        case (sel)
            clock_select_pkg::SEL_TRIM: begin
                val[`TRIM_MSB:0] = st.trim;
            end
            clock_select_pkg::SEL_CONTROL: begin
                val[7:0] = controlImage(st);
            end
            default: begin
                val = 32'h00000000;
            end
        endcase
        return val;
    endfunction

    // Level of a source given selection and synchronised inputs
    function automatic logic srcLevel(input logic selExt, input logic [1:0] div,
                                      input logic intLvl, input logic extLvl,
                                      input logic [2:0] cnt);
        logic lvl;
        lvl = 1'b0;
        if (selExt) begin
            lvl = extLvl;
        end else begin
            case (div)
                `DIV_BY1: lvl = intLvl;
                `DIV_BY2: lvl = cnt[0];
                `DIV_BY4: lvl = cnt[1];
                `DIV_BY8: lvl = cnt[2];
                default: lvl = cnt[2];
            endcase
        end
        return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write and clock switch helpers

    // Data phase write into the addressed register
    function automatic clock_select_pkg::state_t applyWrite(input clock_select_pkg::state_t st,
                                                            input clock_select_pkg::reg_sel_t sel,
                                                            input logic [31:0] wdata);
        clock_select_pkg::state_t nx;
        nx = st;
        case (sel)
            clock_select_pkg::SEL_TRIM: begin
                nx.trim = wdata[`TRIM_MSB:0];
            end
            clock_select_pkg::SEL_CONTROL: begin
                nx.clkSel = wdata[`CTL_CLKSEL_BIT];
                nx.oscEn = wdata[`CTL_ENABLE_BIT];
                nx.divSel = wdata[`CTL_DIV_MSB:`CTL_DIV_LSB];
            end
            default: begin
                nx = st;
            end
        endcase
        return nx;
    endfunction

    // A trim write or a fresh enable restarts the settle count
    function automatic logic writeRestarts(input clock_select_pkg::state_t st,
                                           input clock_select_pkg::reg_sel_t sel,
                                           input logic [31:0] wdata);
        logic rs;
        rs = 1'b0;
        case (sel)
            clock_select_pkg::SEL_TRIM: rs = 1'b1;
            clock_select_pkg::SEL_CONTROL: rs = wdata[`CTL_ENABLE_BIT] & ~st.oscEn;
            default: rs = 1'b0;
        endcase
        return rs;
    endfunction

    // Pending change may be adopted only while old and new levels are low
    function automatic logic switchSafe(input logic pending, input logic curClk, input logic newLvl);
        return pending && !curClk && !newLvl;
    endfunction

    // Address phase accepted on this edge
    function automatic logic phaseTaken(input logic sel, input logic rdy, input logic [1:0] trans);
        return sel & rdy & trans[1];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    clock_select_pkg::state_t s_reg;
    clock_select_pkg::state_t s_next;
    logic intRise;
    logic addrTaken;
    logic restart;
    logic switchReq;
    logic newLevel;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next = s_reg;
        restart = 1'b0;

        // Internal oscillator: two-flop synchroniser and edge history
        s_next.intSync1 = intOscIn;
        s_next.intSync2 = s_reg.intSync1;
        s_next.intPrev = s_reg.intSync2;
        intRise = s_reg.intSync2 & ~s_reg.intPrev;

        // External oscillator: two-flop synchroniser only
        s_next.extSync1 = extOscIn;
        s_next.extSync2 = s_reg.extSync1;

        // Binary divider clocked by internal oscillator edges
        if (intRise) begin
            s_next.divCnt = s_reg.divCnt + 3'h1;
        end

        // Factory trim caught once after reset release
        if (!s_reg.trimLoaded) begin
            s_next.trimLoaded = 1'b1;
            s_next.trim = CALIBRATED ? factoryTrim : UNCAL_TRIM;
        end

        // AHB address phase capture
        addrTaken = phaseTaken(hsel, hready, htrans);
        s_next.dpWrite = addrTaken & hwrite;
        s_next.dpSel = addrTaken ? decodeAddr(haddr) : clock_select_pkg::SEL_NONE;

        // AHB data phase writes; trim writes and fresh enables restart settling
        if (s_reg.dpWrite) begin
            s_next = applyWrite(s_next, s_reg.dpSel, hwdata);
            restart = writeRestarts(s_reg, s_reg.dpSel, hwdata);
        end

        // Frequency ready flag after a settle count of edges
        if (!s_next.oscEn || restart) begin
            s_next.settleCnt = 8'h00;
            s_next.ready = 1'b0;
        end else if (intRise && !s_reg.ready) begin
            s_next.settleCnt = s_reg.settleCnt + 8'h01;
            if (s_reg.settleCnt >= SETTLE_EDGES - 8'h01) begin
                s_next.ready = 1'b1;
            end
        end

        // Source change waits for both old and new clock low
        switchReq = (s_reg.actSel != s_reg.clkSel) || (s_reg.actDiv != s_reg.divSel);
        newLevel = srcLevel(s_reg.clkSel, s_reg.divSel, s_reg.intSync2, s_reg.extSync2, s_reg.divCnt);
        if (switchSafe(switchReq, s_reg.sysClk, newLevel)) begin
            s_next.actSel = s_reg.clkSel;
            s_next.actDiv = s_reg.divSel;
            s_next.sysClk = 1'b0;
        end else begin
            s_next.sysClk = srcLevel(s_reg.actSel, s_reg.actDiv, s_reg.intSync2, s_reg.extSync2,
                                     s_reg.divCnt);
        end

        // Read data registered for the data phase, seeing same-cycle writes
        if (addrTaken && !hwrite) begin
            s_next.rdata = readReg(s_next, decodeAddr(haddr));
        end else begin
            s_next.rdata = 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Reset selects the internal oscillator divided by eight
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.trim <= `TRIM_RST;
            s_reg.trimLoaded <= 1'b0;
            s_reg.clkSel <= RST_CLKSEL;
            s_reg.oscEn <= RST_OSCEN;
            s_reg.divSel <= RST_DIV;
            s_reg.actSel <= 1'b0;
            s_reg.actDiv <= `DIV_RST;
            s_reg.settleCnt <= 8'h00;
            s_reg.ready <= RST_READY;
            s_reg.sysClk <= 1'b0;

            // Synchronisers and divider
            s_reg.intSync1 <= 1'b0;
            s_reg.intSync2 <= 1'b0;
            s_reg.intPrev <= 1'b0;
            s_reg.extSync1 <= 1'b0;
            s_reg.extSync2 <= 1'b0;
            s_reg.divCnt <= 3'h0;

            // Bus data phase
            s_reg.dpWrite <= 1'b0;
            s_reg.dpSel <= clock_select_pkg::SEL_NONE;
            s_reg.rdata <= 32'h00000000;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Registered read data
    assign hrdata = s_reg.rdata;

    // Oscillator controls
    assign oscCtrl.enable = s_reg.oscEn;
    assign oscCtrl.trim = s_reg.trim;

    // System clock and active source
    assign sysClk = s_reg.sysClk;
    assign extSelected = s_reg.actSel;

endmodule
`default_nettype wire

// File: test/system_clock_source_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Clocks
    input wire logic [6:0] factoryTrim,
    input wire clock_select_pkg::osc_ctrl_t oscCtrl,
    input wire logic sysClk,
    input wire logic extSelected
);
    logic take;
    logic ctlWr;
    // Address phase decode
    assign take = hsel && hready && htrans[1];
    assign ctlWr = take && hwrite && haddr == 32'h000002C8;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////
    property p_src_rst; $rose(rst_n) |-> !extSelected; endproperty
    a_src_rst: assert property (p_src_rst) else $error("source not internal after reset");
    property p_trim_load; $rose(rst_n) |=> oscCtrl.trim == $past(factoryTrim); endproperty
    a_trim_load: assert property (p_trim_load) else $error("factory trim not loaded");
    property p_trim_wr; (take && hwrite && haddr == 32'h000002CC) ##1 1 |=> oscCtrl.trim == $past(hwdata[6:0]); endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
    property p_en_wr; ctlWr ##1 1 |=> oscCtrl.enable == $past(hwdata[2]); endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");
    property p_to_ext; ctlWr ##1 hwdata[3] |-> ##[1:200] extSelected; endproperty
    a_to_ext: assert property (p_to_ext) else $error("external source not adopted");
    property p_to_int; ctlWr ##1 !hwdata[3] |-> ##[1:200] !extSelected; endproperty
    a_to_int: assert property (p_to_int) else $error("internal source not adopted");
    property p_sw_low; $changed(extSelected) |-> !$past(sysClk); endproperty
    a_sw_low: assert property (p_sw_low) else $error("source switched while clock high");
    property p_unmapped; take && !hwrite && haddr[31:3] != 29'h00000059 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind system_clock_source_select system_clock_source_select_chk chk_u (.mclk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .factoryTrim, .oscCtrl, .sysClk, .extSelected);
`default_nettype wire

// File: test/test_system_clock_source_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin nErrors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_system_clock_source_select;
    localparam logic [31:0] CTL = 32'h000002C8;
    localparam logic [31:0] TRM = 32'h000002CC;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic intOscIn = 1'b0;
    logic extOscIn = 1'b0;
    clock_select_pkg::osc_ctrl_t oscCtrl;
    logic sysClk;
    logic extSelected;
    logic [3:0] phase = 4'h0;
    int nErrors = 0;
    int totalChecks = 0;
    assign hready = hreadyout;
    system_clock_source_select #(.SETTLE_EDGES(8'h02)) dut_u (.mclk, .rst_n, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .intOscIn, .extOscIn,
        .factoryTrim(7'h5A), .oscCtrl, .sysClk, .extSelected);
    ////////////////////
    // Clock; oscillators of period 4 and 6 cycles
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
        intOscIn <= phase[1];
        extOscIn <= (phase % 4'h6) > 4'h2;
    end
    // Bus cycles and helpers
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wrReg(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask
    task automatic rdReg(input logic [31:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic waitSel(input logic v);
        for (int i = 0; i < 300 && extSelected !== v; i++) @(posedge mclk);
    endtask
    task automatic rises(output int n);
        logic prev;
        prev = sysClk;
        n = 0;
        repeat (96) begin
            @(posedge mclk);
            n += int'(sysClk && !prev);
            prev = sysClk;
        end
    endtask
    ////////////////////
    // Scenarios
    task automatic tReset();
        logic [31:0] d;
        rdReg(CTL, d);
        `CHK("control", 32'h00000014, d)
        rdReg(TRM, d);
        `CHK("trim", 32'h0000005A, d)
        `CHK("extSelected", 1'b0, extSelected)
        `CHK("hresp", 1'b0, hresp)
        $display("tReset done");
    endtask
    task automatic tTrim();
        logic [31:0] d;
        wrReg(32'h000002D0, 32'hFFFFFFFF);
        rdReg(32'h000002D0, d);
        `CHK("unmapped", 32'h0, d)
        wrReg(TRM, 32'hFFFFFFD9);
        rdReg(CTL, d);
        `CHK("ready after trim", 1'b0, d[4])
        rdReg(TRM, d);
        `CHK("trim", 32'h00000059, d)
        `CHK("oscCtrl.trim", 7'h59, oscCtrl.trim)
        repeat (20) @(posedge mclk);
        rdReg(CTL, d);
        `CHK("ready", 1'b1, d[4])
        $display("tTrim done");
    endtask
    task automatic tDivide();
        int n;
        for (int k = 0; k < 4; k++) begin
            wrReg(CTL, 32'h4 | k);
            repeat (40) @(posedge mclk);
            rises(n);
            `CHK("divided rises", 1'b1, n >= (3 << k) - 1 && n <= (3 << k) + 1)
        end
        $display("tDivide done");
    endtask
    task automatic tExt();
        int n;
        wrReg(CTL, 32'h0000000F);
        waitSel(1'b1);
        `CHK("extSelected", 1'b1, extSelected)
        rises(n);
        `CHK("external rises", 1'b1, n >= 15 && n <= 17)
        wrReg(CTL, 32'h00000007);
        waitSel(1'b0);
        `CHK("extSelected", 1'b0, extSelected)
        wrReg(CTL, 32'h0000000F);
        waitSel(1'b1);
        `CHK("extSelected again", 1'b1, extSelected)
        $display("tExt done");
    endtask
    task automatic tEnable();
        logic [31:0] d;
        wrReg(CTL, 32'h0000000B);
        rdReg(CTL, d);
        `CHK("control off", 32'h0000000B, d)
        `CHK("enable", 1'b0, oscCtrl.enable)
        wrReg(CTL, 32'h0000000F);
        rdReg(CTL, d);
        `CHK("control on", 32'h0000000F, d)
        repeat (20) @(posedge mclk);
        rdReg(CTL, d);
        `CHK("control ready", 32'h0000001F, d)
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdReg(CTL, d);
        `CHK("control", 32'h00000014, d)
        `CHK("extSelected", 1'b0, extSelected)
        $display("tEnable done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        tReset();
        tTrim();
        tDivide();
        tExt();
        tEnable();
        conclude();
    end
    // Watchdog
    initial begin
        repeat (8000) @(posedge mclk);
        nErrors++;
        conclude();
    end
endmodule
`default_nettype wire
